// ===== verilog/drive_ring_telegram_cycle.sv
// module: drive end of the ring: repeater, sync timing, command record, reply
//
// Function
// - parameter idents 16 bit, upper half product
// - reply carries own address as source
// - every telegram carries crc, sent, and checked when addressed here or broadcast
// - command holds record per drive, reply one
// - records start with word and container
// - cyclic part of 2, 4, 8 byte items
// - field lengths stay fixed after initialization
// - reply sent only in its own slot
// - sync telegram aligns slot and capture instant
// - sync data is one phase byte
// - telegrams of others repeated unchanged
// - own record taken from configured slot
// - only master starts non-cyclic transfers
// - container 2 bytes, up to 8 later
// - after last portion busy, then segmented reply
// - error flag and reason in one telegram
// - master abort honoured at any time
// - both words carry two real-time bits
module drive_ring_telegram_cycle #(
  parameter int TW = ring_pkg::TIMER_W,
  parameter int DEPTH = ring_pkg::FIFO_DEPTH
)
(
  input wire logic CORE_CLK_I,
  input wire logic RESET_N_I,
  input wire logic [7:0] RX_DATA_I,
  input wire logic RX_LAST_I,
  input wire logic RX_VALID_I,
  output logic RX_READY_O,
  output logic [7:0] TX_DATA_O,
  output logic TX_LAST_O,
  output logic TX_VALID_O,
  input wire logic TX_READY_I,
  input wire logic [7:0] MY_ADDR_I,
  input wire logic [7:0] NUM_DRIVES_I,
  input wire logic [7:0] RECORD_INDEX_I,
  input wire logic [3:0] CONT_LEN_I,
  input wire logic [3:0] CYC_LEN_I,
  input wire logic [TW-1:0] SLOT_START_I,
  input wire logic [TW-1:0] CAPTURE_AT_I,
  input wire logic [15:0] STATUS_I,
  input wire logic [1:0] RT_STATUS_I,
  input wire logic [63:0] FB_DATA_I,
  output logic [7:0] PHASE_O,
  output logic SYNC_O,
  output logic CAPTURE_O,
  output logic CMD_VALID_O,
  output logic [15:0] CTRL_WORD_O,
  output logic [1:0] RT_CMD_O,
  output logic [63:0] CYC_DATA_O,
  output logic FCS_ERR_O,
  output logic NC_RX_VALID_O,
  output logic [63:0] NC_RX_DATA_O,
  output logic NC_RX_LAST_O,
  input wire logic NC_RX_READY_I,
  output logic [15:0] NC_IDENT_O,
  output logic NC_PRODUCT_O,
  output logic NC_ABORT_O,
  output logic NC_BUSY_O,
  input wire logic NC_REPLY_VALID_I,
  input wire logic [63:0] NC_REPLY_DATA_I,
  input wire logic NC_REPLY_LAST_I,
  output logic NC_REPLY_READY_O,
  input wire logic NC_ERR_VALID_I,
  input wire logic [15:0] NC_ERR_CODE_I
);
  typedef struct packed {
    logic rx_ready;
    logic in_frame;
    logic hdr_done;
    logic [7:0] kind;
    logic [7:0] addr;
    logic [7:0] rec_idx;
    logic [4:0] rec_pos;
    logic eval;
    logic [7:0] sync_sh;
    logic [15:0] cw_sh;
    logic [7:0][7:0] cont_sh;
    logic [7:0][7:0] cyc_sh;
    logic [7:0] phase;
    logic [TW-1:0] tmr;
    logic run;
    logic sync_p;
    logic cap_p;
    logic cmd_p;
    logic fcs_err;
    logic [15:0] ctrl;
    logic [63:0] cyc_out;
    logic ahs;
    logic started;
    logic busy;
    logic err;
    logic [15:0] err_code;
    logic rep_sent;
    logic rep_last;
    logic rep_ready;
    logic [7:0][7:0] rep_cont;
    logic nc_rx_p;
    logic nc_last;
    logic [63:0] nc_data;
    logic [15:0] ident;
    logic abort_p;
    logic reply_pend;
    logic own_act;
    logic [4:0] tpos;
    logic fwd_mid;
    logic tx_valid;
    logic tx_last;
    logic [7:0] tx_data;
  } drv_state_t;

  drv_state_t st;
  drv_state_t next_st;
  logic acc;
  logic fo_ready;
  logic tc_valid;
  logic [15:0] crc_rx;
  logic [15:0] crc_tx;
  logic [4:0] cl;
  logic [4:0] cyc;
  logic [4:0] rec_len;
  logic [4:0] own_total;
  logic [4:0] ci;
  logic [4:0] yi;
  logic [7:0] nrec;
  logic [7:0] target;
  logic for_me;
  logic addr_ok;
  logic good;
  logic mhs;
  logic [15:0] sw;
  logic [7:0][7:0] nco;
  logic [7:0][7:0] fbb;
  logic [7:0] own_byte;

  byte_stream_if #(.W(ring_pkg::FIFO_W)) fi ();
  byte_stream_if #(.W(ring_pkg::FIFO_W)) fo ();
  byte_stream_if #(.W(ring_pkg::FIFO_W)) rc ();
  byte_stream_if #(.W(ring_pkg::FIFO_W)) tc ();

  // ***********************************************************************
  // repeater buffer and frame check units
  // ***********************************************************************
  assign acc = RX_VALID_I && st.rx_ready;
  assign fi.valid = acc;
  assign fi.data = {RX_LAST_I, RX_DATA_I};
  assign fo.ready = fo_ready;
  assign rc.valid = acc;
  assign rc.data = fi.data;
  assign rc.ready = 1'b1;
  assign tc.valid = tc_valid;
  assign tc.data = {1'b0, own_byte};
  assign tc.ready = 1'b1;
  assign fbb = FB_DATA_I;

  stream_fifo #(.W(ring_pkg::FIFO_W), .DEPTH(DEPTH)) u_fifo (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RESET_N_I),
    .in_s(fi),
    .out_s(fo)
  );

  crc16_unit u_crc_rx (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RESET_N_I),
    .s(rc),
    .first_i(!st.in_frame),
    .crc_o(crc_rx)
  );

  crc16_unit u_crc_tx (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RESET_N_I),
    .s(tc),
    .first_i(st.tpos == 5'h00),
    .crc_o(crc_tx)
  );

  // ***********************************************************************
  // telegram parsing, cycle timing, handshake and transmit
  // ***********************************************************************
  always_comb
  begin
    next_st = st;
    // container and cyclic sizes per phase
    if (st.phase < ring_pkg::PHASE_FULL)
    begin
      cl = 5'(ring_pkg::CONT_MIN);
      cyc = 5'h00;
    end
    else
    begin
      cl = (CONT_LEN_I > 4'(ring_pkg::CONT_MAX)) ? 5'(ring_pkg::CONT_MAX) :
           (CONT_LEN_I < 4'(ring_pkg::CONT_MIN)) ? 5'(ring_pkg::CONT_MIN) : {1'b0, CONT_LEN_I};
      // sum of 2, 4 and 8 byte items, fixed once configured
      cyc = (CYC_LEN_I > 4'(ring_pkg::CYC_MAX)) ? 5'(ring_pkg::CYC_MAX) : {1'b0, CYC_LEN_I};
    end
    rec_len = (st.kind == ring_pkg::KIND_SYNC) ? 5'h01 : 5'(ring_pkg::FIX_LEN) + cl + cyc;
    own_total = 5'(ring_pkg::HDR_LEN + ring_pkg::FIX_LEN + ring_pkg::FCS_LEN) + cl + cyc;
    for_me = st.addr == MY_ADDR_I;
    addr_ok = for_me || (st.addr == ring_pkg::ADDR_BCAST);
    nrec = (st.kind == ring_pkg::KIND_CMD && !for_me) ? NUM_DRIVES_I : 8'h01;
    target = (st.kind == ring_pkg::KIND_CMD && !for_me) ? RECORD_INDEX_I : 8'h00;
    ci = st.rec_pos - 5'(ring_pkg::FIX_LEN);
    yi = ci - cl;
    good = (crc_rx == ring_pkg::CRC_RESIDUE) && (st.rec_idx == nrec) &&
           (st.rec_pos == 5'(ring_pkg::FCS_LEN));
    mhs = st.cw_sh[ring_pkg::CW_HS];
    next_st.sync_p = 1'b0;
    next_st.cap_p = 1'b0;
    next_st.cmd_p = 1'b0;
    next_st.fcs_err = 1'b0;
    next_st.nc_rx_p = 1'b0;
    next_st.abort_p = 1'b0;
    next_st.eval = 1'b0;
    next_st.rx_ready = fi.ready;

    // receive: header, then records, the fcs counts into record nrec
    if (acc)
    begin
      next_st.in_frame = !RX_LAST_I;
      next_st.eval = RX_LAST_I;
      if (!st.in_frame)
      begin
        next_st.kind = RX_DATA_I;
        next_st.hdr_done = 1'b0;
        next_st.rec_idx = 8'h00;
        next_st.rec_pos = 5'h00;
      end
      else if (!st.hdr_done)
      begin
        next_st.addr = RX_DATA_I;
        next_st.hdr_done = 1'b1;
      end
      else
      begin
        if (st.rec_idx == target && st.rec_pos < rec_len)
        begin
          if (st.kind == ring_pkg::KIND_SYNC)
            next_st.sync_sh = RX_DATA_I;
          else if (st.rec_pos == 5'h00)
            next_st.cw_sh[15:8] = RX_DATA_I;
          else if (st.rec_pos == 5'h01)
            next_st.cw_sh[7:0] = RX_DATA_I;
          else if (ci < cl)
            next_st.cont_sh[ci[2:0]] = RX_DATA_I;
          else
            next_st.cyc_sh[yi[2:0]] = RX_DATA_I;
        end
        if (st.rec_idx != nrec && st.rec_pos == rec_len - 5'h01)
        begin
          next_st.rec_pos = 5'h00;
          next_st.rec_idx = st.rec_idx + 8'h01;
        end
        else if (st.rec_pos != 5'h1f)
          next_st.rec_pos = st.rec_pos + 5'h01;
      end
    end

    // cycle timer from the last sync
    if (st.run && st.tmr != '1)
      next_st.tmr = st.tmr + 1'b1;
    if (st.run && st.tmr == SLOT_START_I && st.phase != ring_pkg::PHASE_ZERO)
      next_st.reply_pend = 1'b1;
    if (st.run && st.tmr == CAPTURE_AT_I)
      next_st.cap_p = 1'b1;

    // reply segments and error from the processing side
    if (st.busy && NC_ERR_VALID_I)
    begin
      next_st.err = 1'b1;
      next_st.err_code = NC_ERR_CODE_I;
      next_st.busy = 1'b0;
      next_st.rep_sent = 1'b0;
    end
    else if (st.busy && !st.rep_sent && NC_REPLY_VALID_I)
    begin
      next_st.rep_cont = NC_REPLY_DATA_I;
      next_st.rep_last = NC_REPLY_LAST_I;
      next_st.rep_sent = 1'b1;
      next_st.ahs = !st.ahs;
    end

    // evaluate a finished telegram one cycle after its last byte
    if (st.eval && addr_ok)
    begin
      if (!good)
        next_st.fcs_err = 1'b1;
      else if (st.kind == ring_pkg::KIND_SYNC)
      begin
        next_st.phase = st.sync_sh;
        next_st.tmr = '0;
        next_st.run = 1'b1;
        next_st.sync_p = 1'b1;
      end
      else if (st.kind == ring_pkg::KIND_CMD && st.phase != ring_pkg::PHASE_ZERO)
      begin
        next_st.cmd_p = 1'b1;
        next_st.ctrl = st.cw_sh;
        next_st.cyc_out = st.cyc_sh;
        if (st.cw_sh[ring_pkg::CW_ABORT])
        begin
          if (st.busy || st.started || st.err)
            next_st.abort_p = 1'b1;
          next_st.busy = 1'b0;
          next_st.started = 1'b0;
          next_st.err = 1'b0;
          next_st.rep_sent = 1'b0;
          next_st.ahs = mhs;
        end
        else if (st.busy)
        begin
          if (st.rep_sent && mhs == st.ahs)
          begin
            next_st.rep_sent = 1'b0;
            next_st.busy = !st.rep_last;
          end
        end
        else if (mhs != st.ahs && NC_RX_READY_I)
        begin
          // only a master toggle opens a portion; untaken ones are resent
          next_st.ahs = mhs;
          next_st.nc_rx_p = 1'b1;
          next_st.nc_data = st.cont_sh;
          next_st.nc_last = st.cw_sh[ring_pkg::CW_LAST];
          next_st.err = 1'b0;
          if (!st.started)
            next_st.ident = {st.cont_sh[0], st.cont_sh[1]};
          next_st.started = !st.cw_sh[ring_pkg::CW_LAST];
          next_st.busy = st.cw_sh[ring_pkg::CW_LAST];
        end
      end
    end
    next_st.rep_ready = next_st.busy && !next_st.rep_sent;

    // own reply contents
    sw = STATUS_I;
    sw[ring_pkg::RT_MSB:ring_pkg::RT_LSB] = RT_STATUS_I;
    sw[ring_pkg::SW_HS] = st.ahs;
    sw[ring_pkg::SW_BUSY] = st.busy;
    sw[ring_pkg::SW_ERR] = st.err;
    nco = (st.busy && st.rep_sent) ? st.rep_cont : '0;
    if (st.err)
    begin
      nco[0] = st.err_code[15:8];
      nco[1] = st.err_code[7:0];
    end
    ci = st.tpos - 5'd4;
    yi = ci - cl;
    if (st.tpos == 5'h00)
      own_byte = ring_pkg::KIND_REPLY;
    else if (st.tpos == 5'h01)
      own_byte = MY_ADDR_I;
    else if (st.tpos == 5'h02)
      own_byte = sw[15:8];
    else if (st.tpos == 5'h03)
      own_byte = sw[7:0];
    else if (ci < cl)
      own_byte = nco[ci[2:0]];
    else if (yi < cyc)
      own_byte = fbb[yi[2:0]];
    else if (st.tpos == own_total - 5'h02)
      own_byte = crc_tx[15:8];
    else
      own_byte = crc_tx[7:0];

    // transmit: own reply in its slot, otherwise repeated bytes
    tc_valid = 1'b0;
    fo_ready = 1'b0;
    if (!st.tx_valid || TX_READY_I)
    begin
      next_st.tx_valid = 1'b0;
      if (st.own_act)
      begin
        next_st.tx_valid = 1'b1;
        next_st.tx_data = own_byte;
        next_st.tx_last = st.tpos == own_total - 5'h01;
        next_st.own_act = st.tpos != own_total - 5'h01;
        next_st.tpos = st.tpos + 5'h01;
        tc_valid = st.tpos < own_total - 5'(ring_pkg::FCS_LEN);
      end
      else if (st.reply_pend && !st.fwd_mid)
      begin
        next_st.own_act = 1'b1;
        next_st.reply_pend = 1'b0;
        next_st.tpos = 5'h00;
      end
      else if (fo.valid)
      begin
        fo_ready = 1'b1;
        next_st.tx_valid = 1'b1;
        next_st.tx_data = fo.data[7:0];
        next_st.tx_last = fo.data[8];
        next_st.fwd_mid = !fo.data[8];
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      st <= '0;
    else
      st <= next_st;
  end

  assign RX_READY_O = st.rx_ready;
  assign TX_DATA_O = st.tx_data;
  assign TX_LAST_O = st.tx_last;
  assign TX_VALID_O = st.tx_valid;
  assign PHASE_O = st.phase;
  assign SYNC_O = st.sync_p;
  assign CAPTURE_O = st.cap_p;
  assign CMD_VALID_O = st.cmd_p;
  assign CTRL_WORD_O = st.ctrl;
  assign RT_CMD_O = st.ctrl[ring_pkg::RT_MSB:ring_pkg::RT_LSB];
  assign CYC_DATA_O = st.cyc_out;
  assign FCS_ERR_O = st.fcs_err;
  assign NC_RX_VALID_O = st.nc_rx_p;
  assign NC_RX_DATA_O = st.nc_data;
  assign NC_RX_LAST_O = st.nc_last;
  assign NC_IDENT_O = st.ident;
  assign NC_PRODUCT_O = st.ident[15];
  assign NC_ABORT_O = st.abort_p;
  assign NC_BUSY_O = st.busy;
  assign NC_REPLY_READY_O = st.rep_ready;
endmodule // drive_ring_telegram_cycle

// ===== verilog/ring_pkg.sv
// package: shared constants of the drive ring telegram block
package ring_pkg;
  // telegram kinds carried in the first byte
  localparam logic [7:0] KIND_SYNC = 8'h01;
  localparam logic [7:0] KIND_CMD = 8'h02;
  localparam logic [7:0] KIND_REPLY = 8'h03;
  localparam logic [7:0] ADDR_BCAST = 8'hff;
  // frame check: crc-16, msb first, residue over data plus fcs
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;
  // byte counts of the telegram parts
  localparam int HDR_LEN = 2;
  localparam int FIX_LEN = 2;
  localparam int FCS_LEN = 2;
  localparam int CONT_MIN = 2;
  localparam int CONT_MAX = 8;
  localparam int CYC_MAX = 8;
  // comm_phase_three and up use full containers and cyclic data; reply slots from phase one
  localparam logic [7:0] PHASE_FULL = 8'h03;
  localparam logic [7:0] PHASE_ZERO = 8'h00;
  localparam logic [15:0] IDENT_STD_MAX = 16'h7fff;
  // control word bits
  localparam int CW_HS = 6;
  localparam int CW_LAST = 5;
  localparam int CW_ABORT = 4;
  // status word bits
  localparam int SW_HS = 6;
  localparam int SW_BUSY = 5;
  localparam int SW_ERR = 4;
  // real-time bits of both words
  localparam int RT_MSB = 15;
  localparam int RT_LSB = 14;
  localparam int TIMER_W = 20;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_W = 9;
endpackage

// ===== verilog/byte_stream_if.sv
// interface: byte stream with valid and ready between the block's modules
interface byte_stream_if #(parameter int W = 9);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
  modport mon (input valid, input data, input ready);
endinterface

// ===== verilog/stream_fifo.sv
// module: first-in first-out buffer for the repeated telegram bytes
module stream_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 32
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  byte_stream_if.snk in_s,
  byte_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic push;
  logic pop;

  always_comb
  begin
    next_st = st;
    push = in_s.valid && (st.cnt != FULL);
    pop = out_s.ready && (st.cnt != '0);
    if (push)
    begin
      next_st.mem[st.wp] = in_s.data;
      next_st.wp = st.wp + 1'b1;
    end
    if (pop)
      next_st.rp = st.rp + 1'b1;
    if (push && !pop)
      next_st.cnt = st.cnt + 1'b1;
    else if (pop && !push)
      next_st.cnt = st.cnt - 1'b1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st <= '0;
    else
      st <= next_st;
  end

  // one slot kept free for a source that sees ready a cycle late
  assign in_s.ready = st.cnt < FULL - 1'b1;
  assign out_s.valid = st.cnt != '0;
  assign out_s.data = st.mem[st.rp];
endmodule // stream_fifo

// ===== verilog/crc16_unit.sv
// module: running frame check sequence over a byte stream
module crc16_unit (
  input wire logic clk_i,
  input wire logic rst_n_i,
  byte_stream_if.mon s,
  input wire logic first_i,
  output logic [15:0] crc_o
);
  typedef struct packed {
    logic [15:0] crc;
  } crc_state_t;

  crc_state_t st;
  crc_state_t next_st;
  logic [15:0] c;
  logic fb;

  always_comb
  begin
    next_st = st;
    c = first_i ? ring_pkg::CRC_INIT : st.crc;
    fb = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      fb = c[15] ^ s.data[7-i];
      c = {c[14:0], 1'b0} ^ (fb ? ring_pkg::CRC_POLY : 16'h0000);
    end
    if (s.valid && s.ready)
      next_st.crc = c;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign crc_o = st.crc;
endmodule // crc16_unit

// ===== dv/drive_ring_telegram_cycle_sva.sv
// checker: port properties of the drive ring telegram block
module drive_ring_telegram_cycle_sva #(
  parameter int TW = ring_pkg::TIMER_W
)
(
  input logic CORE_CLK_I,
  input logic RESET_N_I,
  input logic [7:0] TX_DATA_O,
  input logic TX_LAST_O,
  input logic TX_VALID_O,
  input logic TX_READY_I,
  input logic [TW-1:0] SLOT_START_I,
  input logic [TW-1:0] CAPTURE_AT_I,
  input logic [7:0] PHASE_O,
  input logic SYNC_O,
  input logic CAPTURE_O,
  input logic CMD_VALID_O,
  input logic [15:0] CTRL_WORD_O,
  input logic [1:0] RT_CMD_O,
  input logic FCS_ERR_O,
  input logic [15:0] NC_IDENT_O,
  input logic NC_PRODUCT_O,
  input logic NC_RX_VALID_O
);
  timeunit 1ns;
  timeprecision 1ps;
  // ***
  // time base, one cycle behind the block's own
  // ***
  logic [TW-1:0] timer;
  logic seen;

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      timer <= '0;
      seen <= 1'b0;
    end
    else
    begin
      timer <= SYNC_O ? '0 : timer + 1'b1;
      seen <= seen | SYNC_O;
    end
  end

  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  // ***
  // properties
  // ***
  sequence s_pulse(x);
    x ##1 !x;
  endsequence
  sequence s_reply_head;
    TX_VALID_O && TX_DATA_O == ring_pkg::KIND_REPLY;
  endsequence

  property p_sync_pulse;
    SYNC_O |-> s_pulse(SYNC_O);
  endproperty
  a_sync_pulse: assert property (p_sync_pulse) else $error("sync pulse too long");
  property p_capture;
    seen |-> (CAPTURE_O == (timer == CAPTURE_AT_I));
  endproperty
  a_capture: assert property (p_capture) else $error("capture instant off");
  property p_slot;
    seen && timer == SLOT_START_I && PHASE_O != ring_pkg::PHASE_ZERO && !TX_VALID_O
      |-> ##[1:4] s_reply_head;
  endproperty
  a_slot: assert property (p_slot) else $error("reply not started in slot");
  property p_tx_hold;
    TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O) && $stable(TX_LAST_O);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte changed while stalled");
  property p_phase;
    $changed(PHASE_O) |-> SYNC_O;
  endproperty
  a_phase: assert property (p_phase) else $error("phase changed without sync");
  property p_ctrl;
    $changed(CTRL_WORD_O) |-> CMD_VALID_O;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control word changed alone");
  property p_cmd_rt;
    CMD_VALID_O |-> (RT_CMD_O == CTRL_WORD_O[15:14]) ##0 s_pulse(CMD_VALID_O);
  endproperty
  a_cmd_rt: assert property (p_cmd_rt) else $error("real-time bits wrong");
  property p_fcs;
    FCS_ERR_O |-> !SYNC_O && !CMD_VALID_O && $stable(PHASE_O);
  endproperty
  a_fcs: assert property (p_fcs) else $error("bad telegram was used");
  property p_product;
    NC_RX_VALID_O |=> NC_PRODUCT_O == (NC_IDENT_O > ring_pkg::IDENT_STD_MAX);
  endproperty
  a_product: assert property (p_product) else $error("product flag wrong");
endmodule // drive_ring_telegram_cycle_sva

bind drive_ring_telegram_cycle drive_ring_telegram_cycle_sva #(.TW(TW)) i_sva (
  .CORE_CLK_I(CORE_CLK_I), .RESET_N_I(RESET_N_I), .TX_DATA_O(TX_DATA_O),
  .TX_LAST_O(TX_LAST_O), .TX_VALID_O(TX_VALID_O), .TX_READY_I(TX_READY_I),
  .SLOT_START_I(SLOT_START_I), .CAPTURE_AT_I(CAPTURE_AT_I), .PHASE_O(PHASE_O),
  .SYNC_O(SYNC_O), .CAPTURE_O(CAPTURE_O), .CMD_VALID_O(CMD_VALID_O),
  .CTRL_WORD_O(CTRL_WORD_O), .RT_CMD_O(RT_CMD_O), .FCS_ERR_O(FCS_ERR_O),
  .NC_IDENT_O(NC_IDENT_O), .NC_PRODUCT_O(NC_PRODUCT_O), .NC_RX_VALID_O(NC_RX_VALID_O)
);

// ===== dv/ring_master_model.sv
// partner: ring master feeding telegrams in and collecting output
module ring_master_model (
  input logic clk_i,
  input logic rst_n_i,
  output logic [7:0] rx_data_o,
  output logic rx_last_o,
  output logic rx_valid_o,
  input logic rx_ready_i,
  input logic [7:0] tx_data_i,
  input logic tx_last_i,
  input logic tx_valid_i,
  output logic tx_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] pend[$];
  logic [8:0] got[$];
  logic [7:0] want_a = 8'h07;
  int nlast = 0;
  bit stall = 1'b0;

  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = ring_pkg::CRC_INIT;
    foreach (b[i])
      for (int k = 7; k >= 0; k--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i][k]) ? ring_pkg::CRC_POLY : 16'h0000);
    return c;
  endfunction

  // spoil flips fcs bits
  task automatic send_tel(input logic [7:0] b[$], input logic [15:0] spoil);
    logic [15:0] f;
    f = crc16(b) ^ spoil;
    b.push_back(f[15:8]);
    b.push_back(f[7:0]);
    @(negedge clk_i);
    foreach (b[i])
      pend.push_back({i == b.size() - 1, b[i]});
  endtask

  // ***
  // byte streams; idle data toggles so stale values never look valid
  // ***
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_valid_o <= 1'b0;
      rx_data_o <= 8'h00;
      rx_last_o <= 1'b0;
      tx_ready_o <= 1'b0;
    end
    else
    begin
      if (rx_valid_o && rx_ready_i)
        pend.delete(0);
      rx_valid_o <= pend.size() > 0;
      rx_data_o <= pend.size() > 0 ? pend[0][7:0] : ~rx_data_o;
      rx_last_o <= pend.size() > 0 ? pend[0][8] : ~rx_last_o;
      if (tx_valid_i && tx_ready_o)
      begin
        got.push_back({tx_last_i, tx_data_i});
        if (tx_last_i && (got[0] != {1'b0, ring_pkg::KIND_REPLY} || got[1][7:0] != want_a))
          got.delete();
        else if (tx_last_i)
          nlast++;
      end
      tx_ready_o <= !stall || !tx_ready_o;
    end
  end
endmodule // ring_master_model

// ===== dv/tb_drive_ring_telegram_cycle.sv
// testbench: directed scenarios for the drive ring telegram block
module tb_drive_ring_telegram_cycle;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] rx_data, tx_data, phase;
  logic rx_last, rx_valid, rx_ready, tx_last, tx_valid, tx_ready;
  logic [7:0] my_addr = 8'h07;
  logic [7:0] num_drives = 8'h03;
  logic [7:0] rec_idx = 8'h01;
  logic [3:0] cont_len = 4'h4;
  logic [3:0] cyc_len = 4'h4;
  logic [19:0] slot_start = 20'h0003c;
  logic [19:0] capture_at = 20'h0000a;
  logic [15:0] status = 16'h0a00;
  logic [1:0] rt_status = 2'h2;
  logic [63:0] fb_data = 64'h8877665544332211;
  logic nc_ready = 1'b1;
  logic nc_err = 1'b0;
  logic sync, cmd_valid, fcs_err, nc_valid, nc_product, nc_abort;
  logic [15:0] ctrl_word, nc_ident;
  logic [1:0] rt_cmd;
  logic [63:0] cyc_data, nc_data;
  int failures = 0;
  int samples_checked = 0;

  always #25 clk = ~clk;

  drive_ring_telegram_cycle i_dut (
    .CORE_CLK_I(clk), .RESET_N_I(rst_n), .RX_DATA_I(rx_data), .RX_LAST_I(rx_last),
    .RX_VALID_I(rx_valid), .RX_READY_O(rx_ready), .TX_DATA_O(tx_data), .TX_LAST_O(tx_last),
    .TX_VALID_O(tx_valid), .TX_READY_I(tx_ready), .MY_ADDR_I(my_addr),
    .NUM_DRIVES_I(num_drives), .RECORD_INDEX_I(rec_idx), .CONT_LEN_I(cont_len),
    .CYC_LEN_I(cyc_len), .SLOT_START_I(slot_start), .CAPTURE_AT_I(capture_at),
    .STATUS_I(status), .RT_STATUS_I(rt_status), .FB_DATA_I(fb_data), .PHASE_O(phase),
    .SYNC_O(sync), .CAPTURE_O(), .CMD_VALID_O(cmd_valid), .CTRL_WORD_O(ctrl_word),
    .RT_CMD_O(rt_cmd), .CYC_DATA_O(cyc_data), .FCS_ERR_O(fcs_err), .NC_RX_VALID_O(nc_valid),
    .NC_RX_DATA_O(nc_data), .NC_RX_LAST_O(), .NC_RX_READY_I(nc_ready), .NC_IDENT_O(nc_ident),
    .NC_PRODUCT_O(nc_product), .NC_ABORT_O(nc_abort), .NC_BUSY_O(),
    .NC_REPLY_VALID_I(1'b0), .NC_REPLY_DATA_I(64'h0), .NC_REPLY_LAST_I(1'b0),
    .NC_REPLY_READY_O(), .NC_ERR_VALID_I(nc_err), .NC_ERR_CODE_I(16'h5a5a)
  );

  ring_master_model m (
    .clk_i(clk), .rst_n_i(rst_n), .rx_data_o(rx_data), .rx_last_o(rx_last),
    .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .tx_data_i(tx_data), .tx_last_i(tx_last),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_ready)
  );

  // ***
  // shared tasks
  // ***
  task automatic finish_test();
    if (failures == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return sync;
      1: return cmd_valid;
      2: return fcs_err;
      3: return nc_abort;
      default: return m.nlast > 0;
    endcase
  endfunction

  task automatic wait_for(input int sel);
    int n;
    for (n = 0; n < 600 && pick(sel) !== 1'b1; n++)
      @(negedge clk);
    if (n == 600)
    begin
      chk("wait", 64'h1, 64'h0);
      finish_test();
    end
  endtask

  task automatic cmp_tel(input logic [7:0] e[$]);
    logic [15:0] f;
    f = m.crc16(e);
    e = {e, f[15:8], f[7:0]};
    chk("tx length", 64'(e.size()), 64'(m.got.size()));
    foreach (e[i])
      chk("tx byte", 64'({i == e.size() - 1, e[i]}), 64'(m.got[i]));
    m.got.delete();
    m.nlast = 0;
  endtask

  task automatic send_cmd(input logic [15:0] ctrl);
    logic [7:0] e[$];
    logic [7:0] rec[$];
    rec = {ctrl[15:8], ctrl[7:0], 8'h80, 8'h12, 8'h34, 8'h56, 8'ha1, 8'ha2, 8'ha3, 8'ha4};
    e = {ring_pkg::KIND_CMD, ring_pkg::ADDR_BCAST};
    for (int r = 0; r < 3; r++)
      for (int i = 0; i < 10; i++)
        e.push_back(r == 1 ? rec[i] : 8'(8'h11 * r + i));
    m.send_tel(e, 16'h0000);
  endtask

  // ***
  // scenarios
  // ***
  task automatic t_sync_reply(input logic [15:0] sw);
    logic [7:0] e[$];
    m.stall = 1'b1;
    m.want_a = my_addr;
    e = {ring_pkg::KIND_SYNC, ring_pkg::ADDR_BCAST, ring_pkg::PHASE_FULL};
    m.send_tel(e, 16'h0000);
    wait_for(0);
    chk("phase", 64'(ring_pkg::PHASE_FULL), 64'(phase));
    wait_for(4);
    e = {ring_pkg::KIND_REPLY, my_addr, sw[15:8], sw[7:0]};
    for (int i = 0; i < 8; i++)
      e.push_back(i > 3 ? fb_data[8*i-32 +: 8] : i < 2 && sw[4] ? 8'h5a : 8'h00);
    cmp_tel(e);
    m.stall = 1'b0;
  endtask

  task automatic t_bad_fcs();
    logic [7:0] e[$];
    e = {ring_pkg::KIND_SYNC, ring_pkg::ADDR_BCAST, 8'h04};
    m.send_tel(e, 16'h0001);
    wait_for(2);
    chk("phase kept", 64'(ring_pkg::PHASE_FULL), 64'(phase));
  endtask

  task automatic t_foreign();
    logic [7:0] e[$];
    int hits = 0;
    e = {ring_pkg::KIND_SYNC, 8'h09, 8'h04};
    m.send_tel(e, 16'h0000);
    repeat (40)
    begin
      @(negedge clk);
      hits += int'(sync === 1'b1);
    end
    chk("foreign sync", 64'h0, 64'(hits));
  endtask

  task automatic t_repeat();
    logic [7:0] e[$];
    e = {ring_pkg::KIND_REPLY, 8'h05};
    for (int i = 0; i < 10; i++)
      e.push_back(8'(8'h30 + i));
    m.want_a = 8'h05;
    m.stall = 1'b1;
    m.send_tel(e, 16'h0000);
    wait_for(4);
    cmp_tel(e);
    m.stall = 1'b0;
  endtask

  task automatic t_cmd();
    send_cmd(16'h8060);
    wait_for(1);
    chk("ctrl word", 64'h8060, 64'(ctrl_word));
    chk("rt cmd", 64'h2, 64'(rt_cmd));
    chk("cyclic", 64'ha4a3a2a1, 64'(cyc_data[31:0]));
    chk("nc valid", 64'h1, 64'(nc_valid));
    chk("nc data", 64'h56341280, 64'(nc_data[31:0]));
    chk("nc ident", 64'h8012, 64'(nc_ident));
    chk("nc product", 64'h1, 64'(nc_product));
  endtask

  task automatic t_abort();
    send_cmd(16'h0050);
    wait_for(3);
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_sync_reply(16'h8a00);
    t_bad_fcs();
    t_foreign();
    t_repeat();
    t_cmd();
    t_sync_reply(16'h8a60);
    @(posedge clk) nc_err <= 1'b1;
    @(posedge clk) nc_err <= 1'b0;
    t_sync_reply(16'h8a50);
    t_abort();
    finish_test();
  end
endmodule // tb_drive_ring_telegram_cycle
